// File: core/adc_vol_pkg.sv
// Purpose: types for the record-path register bank
// Assumes: nothing
// Notes: constants live in adc_vol_regs.svh
package adc_vol_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef logic [7:0] reg8_t;
	typedef enum logic [1:0] {PH_NONE, PH_DELAY_LEFT, PH_DELAY_RIGHT} phase_mode_e;

endpackage : adc_vol_pkg

// File: core/adc_vol_regs.svh
// Purpose: offsets, field positions, reset values for the record-path register bank
// Assumes: byte addresses on a 32-bit APB, one register per aligned word
// Notes: index constants are the printed offsets; byte address is four times the index
`ifndef ADC_VOL_REGS_SVH
`define ADC_VOL_REGS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_RVOL        8'h54
`define IDX_PHASE       8'h55
`define IDX_AGC1        8'h56
`define IDX_AGC2        8'h57
`define IDX_SSTEP       8'h60
`define IDX_STATUS      8'h61

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define RST_RVOL        8'h00
`define RST_PHASE       8'h00
`define RST_AGC1        8'h00
`define RST_AGC2        8'h00
`define RST_SSTEP       2'h0
`define MASK_RVOL       8'h7F
`define MASK_AGC1       8'hF3
`define MASK_AGC2       8'hFE

// ----------------------------------------------------------------
// field positions, volume limits and soft-step codes
// ----------------------------------------------------------------
`define AGC_EN_BIT      7
`define VOL_MIN         7'h68
`define VOL_MAX         7'h28
`define SSTEP_ONE       2'h0
`define SSTEP_TWO       2'h1
`define SSTEP_OFF       2'h2

`endif

// File: core/adc_volume_phase_agc_regs.sv
// Purpose: APB register bank for right ADC volume, phase adjust and left AGC setup
// Assumes: APB master with 32-bit data, word clock strobe on the mclk domain
// Notes: zero-wait-state slave, pready high in every access phase
//
// What this block does
// - the 7-bit right volume is signed gain in half-dB steps, -12 dB (0x68) to +20 dB (0x28); the register stores any 7-bit code unclamped.
// - after reset the right volume is code 0, unity gain.
// - bit 7 of the right volume register reads zero and is written zero.
// - phase codes 0x80..0xFF delay left data against right.
// - phase code 0, the reset value, applies no relative delay.
// - phase codes 0x01..0x7F delay right data against left.
// - bit 7 of the first AGC register enables left AGC, reset 0.
// - the 3-bit target field selects the AGC regulation target level.
// - the 2-bit gain hysteresis field selects off, 0.5, 1.0 or 1.5 dB.
// - the 2-bit hysteresis in the second AGC register selects 1, 2, 4 dB or off.
// - the 5-bit noise threshold is gate-off at 0, else -30 dB falling 2 dB per code.
// - bits 3..2 of the first AGC register and bit 0 of the second read zero.
// - volume changes step one code per word clock, per two, or at once per soft-step control.
`timescale 1ns/100ps
`default_nettype none
`include "adc_vol_regs.svh"

module adc_volume_phase_agc_regs (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// word clock strobe from datapath
	input  wire logic        word_clk_stb,
	// settings to datapath
	output logic [6:0]       rvol_applied,
	output logic [1:0]       phase_mode,
	output logic [7:0]       phase_code,
	output logic             agc_enable,
	output logic [2:0]       agc_target,
	output logic [1:0]       agc_gain_hyst,
	output logic [1:0]       agc_hyst,
	output logic [4:0]       agc_noise_thr
);

	adc_vol_pkg::reg8_t rvol_ff;
	adc_vol_pkg::reg8_t phase_ff;
	adc_vol_pkg::reg8_t agc1_ff;
	adc_vol_pkg::reg8_t agc2_ff;
	logic [1:0]         sstep_ff;
	logic [6:0]         cur_vol_ff;
	logic               half_ff;
	logic [31:0]        nxt_prdata;
	logic               nxt_err;
	logic [6:0]         nxt_vol;
	logic               wr_en;
	logic               acc;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [11:0] byte_addr(input logic [7:0] idx);
		byte_addr = {2'h0, idx, 2'h0};
	endfunction : byte_addr

	// signed half-dB code to an ordered value for compare
	function automatic logic signed [7:0] vol_sx(input logic [6:0] code);
		vol_sx = {code[6], code};
	endfunction : vol_sx

	assign acc   = psel && penable;
	assign wr_en = acc && pwrite && pstrb[0];

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// reset values and byte-lane-0 writes of all five registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rvol_ff  <= `RST_RVOL;
			phase_ff <= `RST_PHASE;
			agc1_ff  <= `RST_AGC1;
			agc2_ff  <= `RST_AGC2;
			sstep_ff <= `RST_SSTEP;
		end else if (wr_en) begin
			if (paddr == byte_addr(`IDX_RVOL)) begin
				rvol_ff <= pwdata[7:0] & `MASK_RVOL;
			end else if (paddr == byte_addr(`IDX_PHASE)) begin
				phase_ff <= pwdata[7:0];
			end else if (paddr == byte_addr(`IDX_AGC1)) begin
				agc1_ff <= pwdata[7:0] & `MASK_AGC1;
			end else if (paddr == byte_addr(`IDX_AGC2)) begin
				agc2_ff <= pwdata[7:0] & `MASK_AGC2;
			end else if (paddr == byte_addr(`IDX_SSTEP)) begin
				sstep_ff <= pwdata[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_err    = 1'b0;
		if (paddr == byte_addr(`IDX_RVOL)) begin
			nxt_prdata[7:0] = rvol_ff;
		end else if (paddr == byte_addr(`IDX_PHASE)) begin
			nxt_prdata[7:0] = phase_ff;
		end else if (paddr == byte_addr(`IDX_AGC1)) begin
			nxt_prdata[7:0] = agc1_ff;
		end else if (paddr == byte_addr(`IDX_AGC2)) begin
			nxt_prdata[7:0] = agc2_ff;
		end else if (paddr == byte_addr(`IDX_SSTEP)) begin
			nxt_prdata[1:0] = sstep_ff;
		end else if (paddr == byte_addr(`IDX_STATUS)) begin
			nxt_prdata[7:0] = {half_ff, cur_vol_ff};
		end else begin
			nxt_err = 1'b1;
		end
	end

	// pready/prdata/pslverr registered, valid in access phase
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? nxt_prdata : 32'h0000_0000;
			pslverr <= psel && !penable && nxt_err;
		end
	end

	// ----------------------------------------------------------------
	// volume soft-step
	// ----------------------------------------------------------------
	// signed step toward target
	always_comb begin
		nxt_vol = cur_vol_ff;
		if (vol_sx(cur_vol_ff) < vol_sx(rvol_ff[6:0])) begin
			nxt_vol = 7'(cur_vol_ff + 7'h01);
		end else if (vol_sx(cur_vol_ff) > vol_sx(rvol_ff[6:0])) begin
			nxt_vol = 7'(cur_vol_ff - 7'h01);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cur_vol_ff <= 7'h00;
			half_ff    <= 1'b0;
		end else if (sstep_ff == `SSTEP_OFF || sstep_ff == 2'h3) begin
			cur_vol_ff <= rvol_ff[6:0];
			half_ff    <= 1'b0;
		end else if (word_clk_stb) begin
			half_ff <= !half_ff;
			if (sstep_ff == `SSTEP_ONE || half_ff) begin
				cur_vol_ff <= nxt_vol;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs to datapath
	// ----------------------------------------------------------------
	// phase direction decode
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rvol_applied  <= 7'h00;
			phase_mode    <= adc_vol_pkg::PH_NONE;
			phase_code    <= 8'h00;
			agc_enable    <= 1'b0;
			agc_target    <= 3'h0;
			agc_gain_hyst <= 2'h0;
			agc_hyst      <= 2'h0;
			agc_noise_thr <= 5'h00;
		end else begin
			rvol_applied  <= cur_vol_ff;
			phase_code    <= phase_ff;
			if (phase_ff == 8'h00) begin
				phase_mode <= adc_vol_pkg::PH_NONE;
			end else if (phase_ff[7]) begin
				phase_mode <= adc_vol_pkg::PH_DELAY_LEFT;
			end else begin
				phase_mode <= adc_vol_pkg::PH_DELAY_RIGHT;
			end
			agc_enable    <= agc1_ff[`AGC_EN_BIT];
			agc_target    <= agc1_ff[6:4];
			agc_gain_hyst <= agc1_ff[1:0];
			agc_hyst      <= agc2_ff[7:6];
			agc_noise_thr <= agc2_ff[5:1];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_rvol_bit7_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		!rvol_ff[7]) else $error("volume bit 7 set");

	a_agc_resv_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		(agc1_ff[3:2] == 2'h0) && !agc2_ff[0]) else $error("agc reserved bits set");

	a_phase_left: assert property (@(posedge mclk) disable iff (!rst_n)
		phase_ff[7] |=> phase_mode == adc_vol_pkg::PH_DELAY_LEFT)
		else $error("left delay not selected");

	a_phase_none: assert property (@(posedge mclk) disable iff (!rst_n)
		phase_ff == 8'h00 |=> phase_mode == adc_vol_pkg::PH_NONE)
		else $error("no-delay not selected");

	a_phase_right: assert property (@(posedge mclk) disable iff (!rst_n)
		(phase_ff != 8'h00 && !phase_ff[7]) |=> phase_mode == adc_vol_pkg::PH_DELAY_RIGHT)
		else $error("right delay not selected");

	a_agc_enable: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_en && paddr == byte_addr(`IDX_AGC1) |=> ##1 agc_enable == $past(pwdata[7], 2))
		else $error("agc enable not applied");

	a_vol_write: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_en && paddr == byte_addr(`IDX_RVOL) |=> rvol_ff[6:0] == $past(pwdata[6:0]))
		else $error("volume write lost");

	a_step_off: assert property (@(posedge mclk) disable iff (!rst_n)
		sstep_ff == `SSTEP_OFF |=> cur_vol_ff == $past(rvol_ff[6:0]))
		else $error("immediate volume not applied");

	a_step_one: assert property (@(posedge mclk) disable iff (!rst_n)
		!word_clk_stb && sstep_ff != `SSTEP_OFF && sstep_ff != 2'h3 |=> $stable(cur_vol_ff))
		else $error("volume moved without word clock");

	a_noise_thr: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_en && paddr == byte_addr(`IDX_AGC2) |=> ##1 agc_noise_thr == $past(pwdata[5:1], 2))
		else $error("noise threshold not applied");

endmodule : adc_volume_phase_agc_regs
`default_nettype wire

// File: dv/test_adc_volume_phase_agc_regs.sv
// Purpose: self-checking bench for the record-path register bank
// Assumes: zero-wait APB slave, byte address is four times the index
// Notes: datapath outputs are checked a few cycles after each write
`timescale 1ns/100ps
`default_nettype none
`include "adc_vol_regs.svh"

module test_adc_volume_phase_agc_regs;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, word_clk_stb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [3:0]  pstrb;
	logic [6:0]  rvol_applied;
	logic [1:0]  phase_mode, agc_gain_hyst, agc_hyst;
	logic [7:0]  phase_code;
	logic        agc_enable, rd_err;
	logic [2:0]  agc_target;
	logic [4:0]  agc_noise_thr;
	int          mismatches, tests_run;

	adc_volume_phase_agc_regs adc_volume_phase_agc_regs_i (.mclk(mclk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.word_clk_stb(word_clk_stb), .rvol_applied(rvol_applied), .phase_mode(phase_mode),
		.phase_code(phase_code), .agc_enable(agc_enable), .agc_target(agc_target),
		.agc_gain_hyst(agc_gain_hyst), .agc_hyst(agc_hyst), .agc_noise_thr(agc_noise_thr));

	always #5 mclk = ~mclk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task summarize;
		if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
		int n;
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= st;
		@(posedge mclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			mismatches++;
			summarize();
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, {2'h0, idx, 2'h0}, {24'h0, d}, 4'hF);
		repeat (3) @(posedge mclk);
	endtask : wr

	task rd(input logic [7:0] idx);
		apb(1'b0, {2'h0, idx, 2'h0}, 32'h0, 4'h0);
	endtask : rd

	task strobe(input int k);
		repeat (k) begin
			@(posedge mclk) word_clk_stb <= 1'b1;
			@(posedge mclk) word_clk_stb <= 1'b0;
		end
		repeat (2) @(posedge mclk);
	endtask : strobe

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		for (int i = 0; i < 4; i++) begin
			rd(`IDX_RVOL + 8'(i));
			chk(rd_data, 32'h0, "reset read");
		end
		chk(rvol_applied, 7'h00, "reset volume");
		chk(phase_mode, 2'h0, "reset phase");
		chk(agc_enable, 1'b0, "reset agc");
	endtask : t_reset

	// only legal codes, bit 7 zero
	task t_volume;
		wr(`IDX_SSTEP, 8'h02);
		wr(`IDX_RVOL, 8'h68);
		rd(`IDX_RVOL);
		chk(rd_data, 32'h68, "vol bit7");
		chk(rvol_applied, 7'h68, "vol min");
		wr(`IDX_RVOL, 8'h28);
		chk(rvol_applied, 7'h28, "vol max");
		apb(1'b1, {2'h0, `IDX_RVOL, 2'h0}, 32'h10, 4'h0);
		rd(`IDX_RVOL);
		chk(rd_data, 32'h28, "strobe off");
	endtask : t_volume

	task t_phase;
		logic [7:0] codes [5] = '{8'h80, 8'hFF, 8'h00, 8'h01, 8'h7F};
		logic [1:0] modes [5] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2};
		for (int i = 0; i < 5; i++) begin
			wr(`IDX_PHASE, codes[i]);
			chk(phase_mode, modes[i], "phase mode");
			chk(phase_code, codes[i], "phase code");
		end
	endtask : t_phase

	task t_agc;
		wr(`IDX_AGC1, 8'hF3);
		rd(`IDX_AGC1);
		chk(rd_data, 32'hF3, "agc1 reserved");
		chk({agc_enable, agc_target, agc_gain_hyst}, 6'h3F, "agc1 all");
		wr(`IDX_AGC1, 8'h51);
		chk({agc_enable, agc_target, agc_gain_hyst}, 6'h15, "agc1 mix");
		wr(`IDX_AGC2, 8'hFE);
		rd(`IDX_AGC2);
		chk(rd_data, 32'hFE, "agc2 reserved");
		chk({agc_hyst, agc_noise_thr}, 7'h7F, "agc2 all");
		wr(`IDX_AGC2, 8'h42);
		chk({agc_hyst, agc_noise_thr}, 7'h21, "agc2 mix");
	endtask : t_agc

	task t_unmapped;
		rd(8'h00);
		chk(32'(rd_err), 32'h1, "unmapped error");
		chk(rd_data, 32'h0, "unmapped read");
		rd(`IDX_AGC2);
		chk(32'(rd_err), 32'h0, "mapped error");
		chk(rd_data, 32'h42, "mapped read");
	endtask : t_unmapped

	task t_soft;
		wr(`IDX_RVOL, 8'h00);
		wr(`IDX_SSTEP, 8'h00);
		wr(`IDX_RVOL, 8'h02);
		chk(rvol_applied, 7'h00, "no strobe");
		strobe(1);
		chk(rvol_applied, 7'h01, "step one");
		strobe(2);
		chk(rvol_applied, 7'h02, "step hold");
		wr(`IDX_SSTEP, 8'h01);
		wr(`IDX_RVOL, 8'h7F);
		strobe(2);
		chk(rvol_applied, 7'h01, "half rate");
		strobe(4);
		chk(rvol_applied, 7'h7F, "signed step");
		rd(`IDX_STATUS);
		chk(rd_data[6:0], 7'h7F, "status volume");
		rd(`IDX_SSTEP);
		chk(rd_data, 32'h1, "step readback");
	endtask : t_soft

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; word_clk_stb = 1'b0;
		mismatches = 0; tests_run = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_volume();
		t_phase();
		t_agc();
		t_unmapped();
		t_soft();
		summarize();
	end
endmodule : test_adc_volume_phase_agc_regs
`default_nettype wire
